// file: hdl/timer16_counter.sv
// Counter core of a 16-bit timer with byte-wide CPU access and shared high-byte holding
`timescale 1ns/1ns

// Notes on behaviour
// RULE_01: 16-bit up/down counter, moves only on ticks
// RULE_02: Counter seen as high and low byte locations
// RULE_03: High-byte location accesses the holding register
// RULE_04: Low-byte read copies upper byte into holding
// RULE_05: Low-byte write loads holding and written byte
// RULE_06: Each tick clears, increments or decrements per mode
// RULE_07: Tick source picked by three-bit clock select
// RULE_08: Clock select zero stops all ticks
// RULE_09: CPU may access counter at any time
// RULE_10: CPU write beats count or clear
// RULE_11: Four-bit waveform mode sets count sequence
// RULE_12: Overflow flag set per mode, interrupt capable
// RULE_13: Count strobe moves by one, direction chooses way
// RULE_14: Clear forces zero on the next tick
// RULE_15: Top and floor reached produce indications
// RULE_16: Software masks interrupts around two-byte accesses
// RULE_17: Holding register may be written once, reused
// RULE_18: Write high then low; read low then high
// RULE_19: Holding shared; compare reads bypass it
// RULE_20: Floor zero; ceiling fixed, compare or capture
// RULE_21: Tick is a one-cycle enable on clk_sys
module timer16_counter (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // CPU I/O bus, one byte per access
  input  wire logic [3:0]  io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // External tick pin, asynchronous
  input  wire logic        ext_tick_pin,
  // Status towards the rest of the chip
  output logic             overflow_flag,
  output logic             reached_top,
  output logic             reached_floor,
  output logic      [15:0] timer_count_value
);

  // Returns true when the low bits of the prescaler are all ones
  function automatic logic presc_hit(input logic [9:0] p, input int bits);
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < bits; i++) begin
      hit = hit & p[i];
    end
    return hit;
  endfunction : presc_hit

  // Counting style for a waveform mode
  // Modes not listed fall back to a plain up count to the maximum
  function automatic timer16_pkg::count_style_e style_of(input logic [3:0] m);
    timer16_pkg::count_style_e s;
    case (m)
      4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB: s = timer16_pkg::STYLE_DUAL;
      4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF: s = timer16_pkg::STYLE_TOP_CLEAR;
      default:                                  s = timer16_pkg::STYLE_UP;
    endcase
    return s;
  endfunction : style_of

  // Ceiling source for a waveform mode
  function automatic timer16_pkg::top_src_e top_src_of(input logic [3:0] m);
    timer16_pkg::top_src_e t;
    case (m)
      4'h1, 4'h5:             t = timer16_pkg::TOP_FIX8;
      4'h2, 4'h6:             t = timer16_pkg::TOP_FIX9;
      4'h3, 4'h7:             t = timer16_pkg::TOP_FIX10;
      4'h4, 4'h9, 4'hB, 4'hF: t = timer16_pkg::TOP_CMP;
      4'h8, 4'hA, 4'hC, 4'hE: t = timer16_pkg::TOP_CAPT;
      default:                t = timer16_pkg::TOP_MAX;
    endcase
    return t;
  endfunction : top_src_of

  // Pin synchroniser; stage one is read only by stage two
  logic       pin_meta;     // First stage
  logic       pin_sync;     // Second stage, safe to use
  logic       pin_prev;     // Previous synchronised level, for edges

  // Register state
  logic [7:0]  ctrl_a;         // timer_control_a
  logic [7:0]  ctrl_b;         // timer_control_b
  logic [15:0] count;          // timer_count_value
  logic [7:0]  hold_high;      // Shared high-byte holding register
  // Compare A is not double buffered: a new value acts on the next tick
  logic [15:0] cmp_a;          // Compare A, used as a ceiling
  logic [15:0] capt;           // capture_register, used as a ceiling
  logic        count_up;       // Direction for dual-slope modes
  logic        ovf;            // Sticky overflow flag
  logic [9:0]  presc;          // Free running prescaler
  logic [7:0]  rdata;          // Registered read data
  logic        at_top;         // Registered top indication
  logic        at_floor;       // Registered floor indication

  // Next values
  logic [7:0]  next_ctrl_a;
  logic [7:0]  next_ctrl_b;
  logic [15:0] next_count;
  logic [7:0]  next_hold_high;
  logic [15:0] next_cmp_a;
  logic [15:0] next_capt;
  logic        next_count_up;
  logic        next_ovf;
  logic [9:0]  next_presc;
  logic [7:0]  next_rdata;
  logic        next_at_top;
  logic        next_at_floor;

  // Decoded mode and helpers
  // Decoded from the live control bytes, so a change acts on the next tick
  logic [3:0]  wgm;            // waveform_mode_select
  logic [2:0]  cs;             // clock_source_select
  logic        tick;           // timer_tick, one cycle wide
  logic [15:0] top_val;        // Current ceiling
  logic        ovf_set;        // Overflow event this cycle
  logic        is_top;         // Counter equals ceiling
  logic        is_floor;       // Counter equals floor
  timer16_pkg::count_style_e style;
  timer16_pkg::top_src_e     tsrc;

  // Mode fields are split over both control registers
  assign wgm = {ctrl_b[timer16_pkg::WGM_HI_LSB +: 2],
                ctrl_a[timer16_pkg::WGM_LO_LSB +: 2]};  // see RULE_11
  assign cs  = ctrl_b[timer16_pkg::CS_LSB +: 3];

  // Tick selection; ticks are enables so no second clock domain exists
  // Pin edges come from synchronised levels, never from the raw pin
  // The prescaler never stops, so the first tick after a select change
  // may come early; software that needs a clean start rewrites the count
  always_comb begin
    case (cs)  // see RULE_07
      3'h0:    tick = 1'b0;  // see RULE_08
      3'h1:    tick = 1'b1;  // see RULE_21
      3'h2:    tick = presc_hit(presc, timer16_pkg::DIV8_BITS);
      3'h3:    tick = presc_hit(presc, timer16_pkg::DIV64_BITS);
      3'h4:    tick = presc_hit(presc, timer16_pkg::DIV256_BITS);
      3'h5:    tick = presc_hit(presc, timer16_pkg::DIV1024_BITS);
      3'h6:    tick = pin_prev & ~pin_sync;  // Falling edge of the pin
      default: tick = ~pin_prev & pin_sync;  // Rising edge of the pin
    endcase
  end

  // Ceiling of the sequence for the selected mode
  // A ceiling below the count is passed by; the count runs on and wraps
  always_comb begin
    style = style_of(wgm);
    tsrc  = top_src_of(wgm);
    case (tsrc)  // see RULE_20
      timer16_pkg::TOP_FIX8:  top_val = timer16_pkg::TOP_8BIT;
      timer16_pkg::TOP_FIX9:  top_val = timer16_pkg::TOP_9BIT;
      timer16_pkg::TOP_FIX10: top_val = timer16_pkg::TOP_10BIT;
      timer16_pkg::TOP_CMP:   top_val = cmp_a;
      timer16_pkg::TOP_CAPT:  top_val = capt;
      default:                top_val = timer16_pkg::SEQ_MAX;
    endcase
    is_top   = (count == top_val);                   // see RULE_15
    is_floor = (count == timer16_pkg::SEQ_FLOOR);    // see RULE_15
  end

  // Pin synchroniser registers
  // Pin levels shorter than one clock may be missed, and every edge
  // is seen two clocks late
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= ext_tick_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // Next values of counter, registers and read data
  always_comb begin
    next_ctrl_a    = ctrl_a;
    next_ctrl_b    = ctrl_b;
    next_count     = count;
    next_hold_high = hold_high;
    next_cmp_a     = cmp_a;
    next_capt      = capt;
    next_count_up  = count_up;
    next_presc     = presc + 10'h001;
    next_rdata     = rdata;
    next_at_top    = 1'b0;
    next_at_floor  = 1'b0;
    ovf_set        = 1'b0;

    // Count step on a tick only
    if (tick) begin  // see RULE_01
      case (style)  // see RULE_06
        timer16_pkg::STYLE_DUAL: begin
          // Direction turns at the ceiling and at the floor
          // The flag marks one full period, raised only when turning at the floor
          if (count_up && is_top) begin
            next_count_up = 1'b0;
            next_count    = count - 16'h0001;  // see RULE_13
          end else if (!count_up && is_floor) begin
            next_count_up = 1'b1;
            next_count    = count + 16'h0001;
            ovf_set       = 1'b1;  // see RULE_12
          end else if (count_up) begin
            next_count    = count + 16'h0001;
          end else begin
            next_count    = count - 16'h0001;
          end
        end
        timer16_pkg::STYLE_TOP_CLEAR: begin
          if (is_top) begin
            next_count = timer16_pkg::SEQ_FLOOR;  // see RULE_14
          end else begin
            next_count = count + 16'h0001;
          end
          // Fixed and pwm ceilings flag at the ceiling, clear-on-match at max
          if (wgm == 4'h4 || wgm == 4'hC) begin
            ovf_set = (count == timer16_pkg::SEQ_MAX);  // see RULE_12
          end else begin
            ovf_set = is_top;
          end
        end
        default: begin
          next_count = count + 16'h0001;
          ovf_set    = (count == timer16_pkg::SEQ_MAX);
        end
      endcase
    end

    // Only low-byte writes touch the counter itself; the high byte always
    // passes through the holding register, so a word lands in one edge
    // CPU writes come last so they override the step
    if (io_wr) begin  // see RULE_09
      if (io_addr == timer16_pkg::ADDR_CTRL_A) begin
        next_ctrl_a = io_wdata;
      end else if (io_addr == timer16_pkg::ADDR_CTRL_B) begin
        next_ctrl_b = io_wdata;
      end else if (io_addr == timer16_pkg::ADDR_CNT_LOW) begin
        next_count = {hold_high, io_wdata};  // see RULE_05 see RULE_10
      end else if (io_addr == timer16_pkg::ADDR_CNT_HIGH ||
                   io_addr == timer16_pkg::ADDR_CMP_HIGH ||
                   io_addr == timer16_pkg::ADDR_CAPT_HIGH) begin
        next_hold_high = io_wdata;  // see RULE_03 see RULE_19
      end else if (io_addr == timer16_pkg::ADDR_CMP_LOW) begin
        next_cmp_a = {hold_high, io_wdata};
      end else if (io_addr == timer16_pkg::ADDR_CAPT_LOW) begin
        // Capture is only writable while it sets the ceiling
        if (tsrc == timer16_pkg::TOP_CAPT) begin
          next_capt = {hold_high, io_wdata};
        end
      end
    end

    // Indications follow the value the counter really takes, so a CPU
    // write at a tick edge cannot raise a pulse for a value never held
    if (tick) begin
      next_at_top   = (next_count == top_val);                 // see RULE_15
      next_at_floor = (next_count == timer16_pkg::SEQ_FLOOR);  // see RULE_15
    end

    // A low read and a high write in one cycle: the read's copy into the
    // holding register wins, as it comes last
    // CPU reads; data appears on io_rdata the cycle after the strobe
    if (io_rd) begin  // see RULE_02
      if (io_addr == timer16_pkg::ADDR_CTRL_A) begin
        next_rdata = ctrl_a;
      end else if (io_addr == timer16_pkg::ADDR_CTRL_B) begin
        next_rdata = ctrl_b;
      end else if (io_addr == timer16_pkg::ADDR_CNT_LOW) begin
        next_rdata     = count[7:0];
        next_hold_high = count[15:8];  // see RULE_04
      end else if (io_addr == timer16_pkg::ADDR_CNT_HIGH ||
                   io_addr == timer16_pkg::ADDR_CAPT_HIGH) begin
        next_rdata = hold_high;  // see RULE_03
      end else if (io_addr == timer16_pkg::ADDR_CMP_LOW) begin
        next_rdata = cmp_a[7:0];
      end else if (io_addr == timer16_pkg::ADDR_CMP_HIGH) begin
        next_rdata = cmp_a[15:8];  // see RULE_19
      end else if (io_addr == timer16_pkg::ADDR_CAPT_LOW) begin
        next_rdata     = capt[7:0];
        next_hold_high = capt[15:8];
      end else if (io_addr == timer16_pkg::ADDR_FLAGS) begin
        next_rdata = {7'h00, ovf};
      end else begin
        next_rdata = 8'h00;  // Unmapped locations read zero
      end
    end

    // Sticky flag: a new event wins over a clear in the same cycle
    next_ovf = ovf;
    if (io_wr && io_addr == timer16_pkg::ADDR_FLAGS && io_wdata[timer16_pkg::OVF_BIT]) begin
      next_ovf = 1'b0;
    end
    if (ovf_set) begin
      next_ovf = 1'b1;  // see RULE_12
    end
  end

  // Register every next value
  // Every register runs on every clk_sys edge; ticks only steer the
  // next values, so nothing here is gated
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_a    <= timer16_pkg::RST_CTRL;
      ctrl_b    <= timer16_pkg::RST_CTRL;
      count     <= timer16_pkg::RST_WORD;
      hold_high <= timer16_pkg::RST_BYTE;
      cmp_a     <= timer16_pkg::RST_WORD;
      capt      <= timer16_pkg::RST_WORD;
      count_up  <= 1'b1;
      ovf       <= 1'b0;
      presc     <= timer16_pkg::RST_PRESC;
      rdata     <= timer16_pkg::RST_BYTE;
      at_top    <= 1'b0;
      at_floor  <= 1'b0;
    end else begin
      ctrl_a    <= next_ctrl_a;
      ctrl_b    <= next_ctrl_b;
      count     <= next_count;
      hold_high <= next_hold_high;
      cmp_a     <= next_cmp_a;
      capt      <= next_capt;
      count_up  <= next_count_up;
      ovf       <= next_ovf;
      presc     <= next_presc;
      rdata     <= next_rdata;
      at_top    <= next_at_top;
      at_floor  <= next_at_floor;
    end
  end

  // Status outputs come straight from flip-flops
  assign overflow_flag     = ovf;
  assign reached_top       = at_top;
  assign reached_floor     = at_floor;
  assign timer_count_value = count;
  assign io_rdata          = rdata;

endmodule : timer16_counter

// file: inc/timer16_pkg.sv
// Constants and types shared by the 16-bit counter core
package timer16_pkg;

  // Byte-wide I/O locations on the CPU data bus
  localparam logic [3:0] ADDR_CTRL_A    = 4'h0;  // timer_control_a
  localparam logic [3:0] ADDR_CTRL_B    = 4'h1;  // timer_control_b
  localparam logic [3:0] ADDR_CNT_LOW   = 4'h2;  // counter_low_byte
  localparam logic [3:0] ADDR_CNT_HIGH  = 4'h3;  // counter_high_byte
  localparam logic [3:0] ADDR_CMP_LOW   = 4'h4;  // compare A, low byte
  localparam logic [3:0] ADDR_CMP_HIGH  = 4'h5;  // compare A, high byte
  localparam logic [3:0] ADDR_CAPT_LOW  = 4'h6;  // capture_register, low byte
  localparam logic [3:0] ADDR_CAPT_HIGH = 4'h7;  // capture_register, high byte
  localparam logic [3:0] ADDR_FLAGS     = 4'h8;  // overflow_flag, write one to clear

  // Field positions
  localparam int CS_LSB       = 0;  // clock_source_select in control B, 3 bits
  localparam int WGM_LO_LSB   = 0;  // waveform_mode_select[1:0] in control A
  localparam int WGM_HI_LSB   = 3;  // waveform_mode_select[3:2] in control B
  localparam int OVF_BIT      = 0;  // overflow_flag in the flag location

  // Reset values
  localparam logic [7:0]  RST_CTRL = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [9:0]  RST_PRESC = 10'h000;

  // Fixed sequence limits
  localparam logic [15:0] SEQ_FLOOR = 16'h0000;
  localparam logic [15:0] SEQ_MAX   = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT  = 16'h00FF;
  localparam logic [15:0] TOP_9BIT  = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // Prescaler taps: log2 of the division ratio
  localparam int DIV8_BITS    = 3;
  localparam int DIV64_BITS   = 6;
  localparam int DIV256_BITS  = 8;
  localparam int DIV1024_BITS = 10;

  // How the counter walks through its sequence
  typedef enum logic [1:0] {STYLE_UP, STYLE_TOP_CLEAR, STYLE_DUAL} count_style_e;

  // Where the ceiling of the sequence comes from
  typedef enum logic [2:0] {
    TOP_MAX, TOP_FIX8, TOP_FIX9, TOP_FIX10, TOP_CMP, TOP_CAPT
  } top_src_e;

endpackage : timer16_pkg

// file: sim/cpu_bus_model.sv
// Behavioural CPU issuing byte accesses on the timer bus
`timescale 1ns/1ns
module cpu_bus_model (
  // Clock
  input  wire logic       clk_sys,
  // Byte bus towards the timer
  output logic      [3:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata,
  input  wire logic [7:0] io_rdata
);
  // Bus idle from time zero
  initial begin
    io_addr  = 4'h0;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // One byte write, strobe held for one clock
  task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge clk_sys);
    io_wr    <= 1'b0;
    io_wdata <= ~d;  // Released data must not look valid
  endtask : wr_byte
  // One byte read, data taken once the registered answer settles
  task automatic rd_byte(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge clk_sys);
    io_rd   <= 1'b0;
    @(negedge clk_sys);
    d = io_rdata;
  endtask : rd_byte
  // Word write: high byte first, no interrupt code can split the pair
  task automatic wr_word(input logic [3:0] lo, input logic [15:0] v);
    wr_byte(lo + 4'h1, v[15:8]);
    wr_byte(lo, v[7:0]);
  endtask : wr_word
  // Word read: low byte first so the high byte is latched with it
  task automatic rd_word(input logic [3:0] lo, output logic [15:0] v);
    rd_byte(lo, v[7:0]);
    rd_byte(lo + 4'h1, v[15:8]);
  endtask : rd_word
endmodule : cpu_bus_model

// file: sim/timer16_counter_monitor.sv
// Port checker for the 16-bit counter core
`timescale 1ns/1ns
module timer16_counter_monitor (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        resetn,
  // CPU byte bus
  input wire logic [3:0]  io_addr,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [7:0]  io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        ext_tick_pin,
  // Status outputs
  input wire logic        overflow_flag,
  input wire logic        reached_top,
  input wire logic        reached_floor,
  input wire logic [15:0] timer_count_value
);
  logic [7:0] ctl_a;  // Shadow of control A
  logic [7:0] ctl_b;  // Shadow of control B
  logic       up1;    // Plain up count with a tick on every clock
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Shadow the control bytes so the active mode is known here
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctl_a <= 8'h00;
      ctl_b <= 8'h00;
    end else if (io_wr && io_addr == timer16_pkg::ADDR_CTRL_A) begin
      ctl_a <= io_wdata;
    end else if (io_wr && io_addr == timer16_pkg::ADDR_CTRL_B) begin
      ctl_b <= io_wdata;
    end
  end
  assign up1 = (ctl_a[1:0] == 2'h0) && (ctl_b[4:0] == 5'h01);
  a_low_read: assert property (
    io_rd && io_addr == timer16_pkg::ADDR_CNT_LOW |=> io_rdata == $past(timer_count_value[7:0]))
    else $error("low byte read wrong");
  a_high_read_latched: assert property (
    io_rd && io_addr == timer16_pkg::ADDR_CNT_HIGH && !io_wr && $past(!io_wr && !io_rd)
    && $past(io_rd && io_addr == timer16_pkg::ADDR_CNT_LOW, 2)
    |=> io_rdata == $past(timer_count_value[15:8], 3)) else $error("high byte read wrong");
  a_low_write_load: assert property (
    io_wr && io_addr == timer16_pkg::ADDR_CNT_LOW && $past(!io_wr && !io_rd)
    && $past(io_wr && io_addr == timer16_pkg::ADDR_CNT_HIGH, 2)
    |=> timer_count_value == {$past(io_wdata, 3), $past(io_wdata)}) else $error("word load wrong");
  a_idle_holds: assert property (
    ctl_b[2:0] == 3'h0 && !io_wr |=> $stable(timer_count_value)) else $error("count moved");
  a_count_step: assert property (
    up1 && !io_wr |=> timer_count_value == $past(timer_count_value) + 16'h0001)
    else $error("count step wrong");
  a_flag_at_wrap: assert property (
    up1 && !io_wr && timer_count_value == 16'hFFFF |=> overflow_flag)
    else $error("overflow flag missing");
  a_rdata_stands: assert property (
    !io_rd |=> $stable(io_rdata)) else $error("read data changed");
  a_unmapped_zero: assert property (
    io_rd && io_addr > timer16_pkg::ADDR_FLAGS |=> io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_floor_pulse: assert property (
    reached_floor |-> timer_count_value == 16'h0000) else $error("floor pulse off zero");
  // Main scenarios reached
  c_wrap: cover property (up1 && timer_count_value == 16'hFFFF);
  c_high_read: cover property (io_rd && io_addr == timer16_pkg::ADDR_CNT_HIGH);
  c_low_write: cover property (io_wr && io_addr == timer16_pkg::ADDR_CNT_LOW);
  c_floor: cover property (reached_floor);
endmodule : timer16_counter_monitor

bind timer16_counter timer16_counter_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn),
  .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
  .ext_tick_pin(ext_tick_pin), .overflow_flag(overflow_flag), .reached_top(reached_top),
  .reached_floor(reached_floor), .timer_count_value(timer_count_value));

// file: sim/timer16_counter_tb.sv
// Self-checking bench for the 16-bit counter core
`timescale 1ns/1ns
module timer16_counter_tb;
  logic        clk_sys;             // 50 MHz system clock
  logic        resetn;              // Active-low reset
  logic        ext_tick_pin;        // External tick pin
  logic [3:0]  io_addr;             // Bus from the CPU model
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic [7:0]  io_rdata;
  logic        overflow_flag;
  logic        reached_top;
  logic        reached_floor;
  logic [15:0] timer_count_value;
  int          n_fail;              // Mismatches
  int          n_compared;          // Comparisons
  timer16_counter u_dut (.clk_sys(clk_sys), .resetn(resetn), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .ext_tick_pin(ext_tick_pin), .overflow_flag(overflow_flag), .reached_top(reached_top),
    .reached_floor(reached_floor), .timer_count_value(timer_count_value));
  cpu_bus_model u_cpu (.clk_sys(clk_sys), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Compare one value and count it
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Bounded wait until the count shows a value
  task automatic wait_count(input logic [15:0] v);
    for (int i = 0; i < 300 && timer_count_value !== v; i++) @(negedge clk_sys);
    check(timer_count_value, v);
  endtask : wait_count
  // Word write and latched read, stopped timer
  task automatic t_word;
    logic [15:0] v;
    u_cpu.wr_word(timer16_pkg::ADDR_CNT_LOW, 16'h01FF);
    @(negedge clk_sys);
    check(timer_count_value, 16'h01FF);
    u_cpu.rd_word(timer16_pkg::ADDR_CNT_LOW, v);
    check(v, 16'h01FF);
    u_cpu.wr_byte(timer16_pkg::ADDR_CNT_HIGH, 8'hA5);
    u_cpu.rd_byte(timer16_pkg::ADDR_CNT_HIGH, v[7:0]);
    check({8'h00, v[7:0]}, 16'h00A5);
    check(timer_count_value, 16'h01FF);
    // One holding write serves two low-byte writes
    u_cpu.wr_byte(timer16_pkg::ADDR_CNT_HIGH, 8'h12);
    u_cpu.wr_byte(timer16_pkg::ADDR_CMP_LOW, 8'h34);
    u_cpu.wr_byte(timer16_pkg::ADDR_CNT_LOW, 8'h56);
    u_cpu.rd_word(timer16_pkg::ADDR_CMP_LOW, v);
    check(v, 16'h1234);
    check(timer_count_value, 16'h1256);
    $display("word access test done");
  endtask : t_word
  // Up count through the wrap, write wins while counting
  task automatic t_count;
    u_cpu.wr_word(timer16_pkg::ADDR_CNT_LOW, 16'hFFF0);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h01);
    wait_count(16'hFFFF);
    @(negedge clk_sys);
    check(timer_count_value, 16'h0000);
    check({15'h0, overflow_flag}, 16'h0001);
    u_cpu.wr_word(timer16_pkg::ADDR_CNT_LOW, 16'h1234);
    @(negedge clk_sys);
    check(timer_count_value, 16'h1234);
    u_cpu.wr_byte(timer16_pkg::ADDR_FLAGS, 8'h01);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h00);
    check({15'h0, overflow_flag}, 16'h0000);
    $display("count test done");
  endtask : t_count
  // Fixed 8-bit ceiling clears to zero and raises the flag
  task automatic t_ceiling;
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_A, 8'h01);
    u_cpu.wr_word(timer16_pkg::ADDR_CNT_LOW, 16'h00F0);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h09);
    wait_count(16'h00FF);
    check({15'h0, reached_top}, 16'h0001);
    @(negedge clk_sys);
    check(timer_count_value, 16'h0000);
    check({15'h0, reached_floor}, 16'h0001);
    @(negedge clk_sys);
    check({15'h0, overflow_flag}, 16'h0001);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h00);
    $display("ceiling test done");
  endtask : t_ceiling
  // External pin ticks, rising then falling edge
  task automatic t_ext;
    logic [7:0] b;
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_A, 8'h00);
    u_cpu.wr_word(timer16_pkg::ADDR_CNT_LOW, 16'h0000);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h07);
    for (int i = 0; i < 4; i++) begin
      repeat (6) @(posedge clk_sys);
      // Switch to falling edges only after the last fall cleared the synchroniser
      if (i == 3) u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h06);
      ext_tick_pin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      ext_tick_pin <= 1'b0;
    end
    repeat (6) @(negedge clk_sys);
    check(timer_count_value, 16'h0004);
    u_cpu.wr_byte(timer16_pkg::ADDR_CTRL_B, 8'h00);
    u_cpu.wr_byte(4'hE, 8'h55);
    u_cpu.rd_byte(4'hF, b);
    check({b, timer_count_value[7:0]}, 16'h0004);
    $display("external tick test done");
  endtask : t_ext
  // Counts and verdict
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  // Hang guard, far beyond the roughly 150 cycles needed
  initial begin
    #100000;
    n_fail++;
    complete_run;
  end
  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    resetn = 1'b0;
    ext_tick_pin = 1'b0;
    repeat (4) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    check({overflow_flag, io_rdata, timer_count_value[6:0]}, 16'h0000);
    t_word;
    t_count;
    t_ceiling;
    t_ext;
    complete_run;
  end
endmodule : timer16_counter_tb
